// *** rtl/mpl_top.sv ***
// controller for the manchester programming link of a programmable sensor
// assumes the sensor output pin is wired through an external buffer from the three pin signals,
// PRG_EN_OUT steers the program-enable level, and all inputs are synchronous to MCLK
`timescale 1ns/10ps
module mpl_top #(
	parameter int unsigned CMD_FIRST_CYC = mpl_pkg::CMD_FIRST_CYC,
	parameter int unsigned NVM_WAIT_CYC  = mpl_pkg::NVM_WAIT_CYC,
	parameter int unsigned RSP_WAIT_CYC  = mpl_pkg::RSP_WAIT_CYC,
	parameter logic [11:0] HALF_CYC      = mpl_pkg::HALF_BIT_CYC
) (
	input  wire logic                 MCLK,
	input  wire logic                 RST_N,
	input  wire logic                 CMD_VALID,
	output logic                      CMD_READY,
	input  wire mpl_pkg::mpl_cmd_type CMD,
	input  wire logic                 PRG_HOLD,
	output logic                      RSP_VALID,
	input  wire logic                 RSP_READY,
	output mpl_pkg::mpl_rsp_type      RSP,
	output logic                      BUSY,
	output logic                      PRG_EN_OUT,
	input  wire logic                 SOUT_I,
	output logic                      SOUT_O,
	output logic                      SOUT_OE
);
	typedef enum logic [3:0] {
		S_OFF,
		S_ENTER,
		S_HELD,
		S_LOW,
		S_SEND,
		S_RX_HUNT,
		S_RX_BITS,
		S_NV_WAIT,
		S_PUSH,
		S_EXIT
	} mpl_state_type;

	localparam int unsigned FRM_W = mpl_pkg::CMD_FRAME_W;
	localparam int unsigned ACK_W = mpl_pkg::ACK_FRAME_W;

	mpl_state_type        state_r;
	mpl_state_type        state_nxt;
	logic [31:0]          cnt_r;
	mpl_pkg::mpl_kind_type kind_r;
	logic [FRM_W-1:0]     tx_sh_r;
	logic [5:0]           tx_left_r;
	logic [ACK_W-1:0]     rx_sh_r;
	logic [5:0]           rx_n_r;
	logic                 pin_prev_r;
	logic                 seen_high_r;
	mpl_pkg::mpl_rsp_type rsp_r;
	mpl_pkg::mpl_rsp_type rsp_nxt;
	logic                 prg_en_r;
	logic                 pin_o_r;
	logic                 pin_oe_r;
	logic                 accept;
	logic                 tx_start;
	logic                 tx_line;
	logic                 tx_done;
	logic                 rise;
	logic                 fall;
	logic                 rx_edge_ok;
	logic                 rx_last;
	logic                 fifo_ready;
	logic [mpl_pkg::ADDR_W-1:0]    addr_sel;
	logic [mpl_pkg::CRC_SPAN_W-1:0] crc_span;

	////////////////////////////////////////////////////////////////////////////////
	// user side handshakes and line edges
	assign CMD_READY  = (state_r == S_OFF) || (state_r == S_HELD);
	assign accept     = CMD_VALID & CMD_READY;
	assign BUSY       = ~CMD_READY;
	assign PRG_EN_OUT = prg_en_r;
	assign SOUT_O     = pin_o_r;
	assign SOUT_OE    = pin_oe_r;
	assign rise       = ~pin_prev_r & SOUT_I;
	assign fall       = pin_prev_r & ~SOUT_I;
	assign rx_edge_ok = (cnt_r >= (3 * HALF_CYC) / 2) & (rise | fall);
	assign rx_last    = (rx_n_r == 6'(ACK_W - 1));

	// unlock address forced
	// unlock commands always target the access-code register
	assign addr_sel = (CMD.kind == mpl_pkg::MPL_UNLOCK) ? mpl_pkg::UNLOCK_ADDR : CMD.addr;
	assign crc_span = {((CMD.kind == mpl_pkg::MPL_READ) ? mpl_pkg::RW_READ : mpl_pkg::RW_WRITE),
		addr_sel, CMD.data};

	////////////////////////////////////////////////////////////////////////////////
	// sequencing of one programming transaction
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_OFF: begin
				if (accept) begin
					state_nxt = S_ENTER;
				end
			end
			S_ENTER: begin
				if (cnt_r == CMD_FIRST_CYC - 1) begin
					state_nxt = S_LOW;
				end
			end
			S_HELD: begin
				if (accept) begin
					state_nxt = S_LOW;
				end else if (!PRG_HOLD) begin
					state_nxt = S_EXIT;
				end
			end
			S_LOW: begin
				if (cnt_r == mpl_pkg::LOW_HOLD_CYC - 1) begin
					state_nxt = S_SEND;
				end
			end
			S_SEND: begin
				if (tx_done && tx_left_r == 6'h00) begin
					case (kind_r)
						mpl_pkg::MPL_READ:      state_nxt = S_RX_HUNT;
						mpl_pkg::MPL_WRITE_NVM: state_nxt = S_NV_WAIT;
						default:                state_nxt = S_PUSH;
					endcase
				end
			end
			S_RX_HUNT: begin
				if (rise || cnt_r == RSP_WAIT_CYC - 1) begin
					state_nxt = rise ? S_RX_BITS : S_PUSH;
				end
			end
			S_RX_BITS: begin
				if ((rx_edge_ok && rx_last) || cnt_r == 3 * HALF_CYC - 1) begin
					state_nxt = S_PUSH;
				end
			end
			S_NV_WAIT: begin
				if ((fall && seen_high_r) || cnt_r == NVM_WAIT_CYC - 1) begin
					state_nxt = S_PUSH;
				end
			end
			S_PUSH: begin
				if (fifo_ready) begin
					state_nxt = PRG_HOLD ? S_HELD : S_EXIT;
				end
			end
			S_EXIT: begin
				if (cnt_r == mpl_pkg::EXIT_GAP_CYC - 1) begin
					state_nxt = S_OFF;
				end
			end
			default: begin
				state_nxt = S_OFF;
			end
		endcase
	end

	// state register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= S_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// cycle counter, restarted on each state change and each received bit
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_r <= 32'h00000000;
		end else if (state_nxt != state_r || (state_r == S_RX_BITS && rx_edge_ok)) begin
			cnt_r <= 32'h00000000;
		end else begin
			cnt_r <= cnt_r + 32'h00000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command frame shifter
	assign tx_start = (state_r == S_LOW && state_nxt == S_SEND)
		|| (state_r == S_SEND && tx_done && tx_left_r != 6'h00);

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_sh_r   <= '0;
			tx_left_r <= 6'h00;
			kind_r    <= mpl_pkg::MPL_UNLOCK;
		end else if (accept) begin
			tx_sh_r   <= {mpl_pkg::SYNC_VAL, crc_span,
				mpl_pkg::mpl_crc3(crc_span, mpl_pkg::CRC_SPAN_W)};
			tx_left_r <= 6'(FRM_W);
			kind_r    <= CMD.kind;
		end else if (tx_start) begin
			tx_sh_r   <= {tx_sh_r[FRM_W-2:0], 1'b0};
			tx_left_r <= tx_left_r - 6'h01;
		end
	end

	mpl_tx_bit #(.HALF_CYC (HALF_CYC)) u_tx_bit (
		.clk     (MCLK),
		.rst_n   (RST_N),
		.start   (tx_start),
		.bit_val (tx_sh_r[FRM_W-1]),
		.line    (tx_line),
		.done    (tx_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// reply receiver: each mid-bit edge gives one bit, the level before it
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_prev_r <= 1'b0;
		end else begin
			pin_prev_r <= SOUT_I;
		end
	end

	// edge direction decode
	// the first rising edge is the mid-bit of the leading sync zero
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_sh_r <= '0;
			rx_n_r  <= 6'h00;
		end else if (state_r == S_RX_HUNT) begin
			rx_sh_r <= '0;
			rx_n_r  <= rise ? 6'h01 : 6'h00;
		end else if (state_r == S_RX_BITS && rx_edge_ok) begin
			rx_sh_r <= {rx_sh_r[ACK_W-2:0], pin_prev_r};
			rx_n_r  <= rx_n_r + 6'h01;
		end
	end

	// completion needs a high level first
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			seen_high_r <= 1'b0;
		end else if (state_r != S_NV_WAIT) begin
			seen_high_r <= 1'b0;
		end else if (SOUT_I) begin
			seen_high_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// answer built for the user, one per command
	always_comb begin
		rsp_nxt        = rsp_r;
		rsp_nxt.status = mpl_pkg::MPL_OK;
		if (state_r == S_LOW) begin
			rsp_nxt = '0;
		end else if (state_r == S_RX_HUNT) begin
			rsp_nxt.status = mpl_pkg::MPL_NO_REPLY;
		end else if (state_r == S_RX_BITS) begin
			rsp_nxt.ecc  = rx_sh_r[mpl_pkg::ECC_LSB+mpl_pkg::CRC_W-2 -: mpl_pkg::ECC_W];
			rsp_nxt.data = {rx_sh_r[mpl_pkg::PAYLOAD_W-2:0], pin_prev_r};
			rsp_nxt.status = mpl_pkg::MPL_NO_REPLY;
			if (rx_edge_ok && rx_last) begin
				if ({rx_sh_r[ACK_W-2:ACK_W-3]} != mpl_pkg::SYNC_VAL
					|| mpl_pkg::mpl_crc3({rx_sh_r[ACK_W-4:mpl_pkg::CRC_W-1], 7'h00},
						mpl_pkg::DATA_W) != {rx_sh_r[1:0], pin_prev_r}) begin
					rsp_nxt.status = mpl_pkg::MPL_CRC_BAD;
				end else begin
					rsp_nxt.status = mpl_pkg::MPL_OK;
					rsp_nxt.ecc    = rx_sh_r[mpl_pkg::ECC_LSB+mpl_pkg::CRC_W-1 +: mpl_pkg::ECC_W];
					rsp_nxt.data   = rx_sh_r[mpl_pkg::PAYLOAD_W+mpl_pkg::CRC_W-2:mpl_pkg::CRC_W-1];
				end
			end
		end else if (state_r == S_NV_WAIT) begin
			rsp_nxt.status = (fall && seen_high_r) ? mpl_pkg::MPL_OK : mpl_pkg::MPL_NO_REPLY;
		end
	end

	// answer register, frozen while waiting to enter the buffer
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rsp_r <= '0;
		end else if (state_r != S_PUSH && state_nxt != state_r) begin
			rsp_r <= rsp_nxt;
		end
	end

	// unlocks and volatile writes answered locally
	// two-entry buffer; a full buffer holds the controller in S_PUSH
	mpl_fifo #(
		.W     ($bits(mpl_pkg::mpl_rsp_type)),
		.DEPTH (2)
	) u_rsp_fifo (
		.clk       (MCLK),
		.rst_n     (RST_N),
		.in_valid  (state_r == S_PUSH),
		.in_ready  (fifo_ready),
		.in_data   (rsp_r),
		.out_valid (RSP_VALID),
		.out_ready (RSP_READY),
		.out_data  (RSP)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin and enable drivers, registered
	// program enable raised
	// controller owns the pin while enabled, except from the end of sending a read or nonvolatile write until S_HELD
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			prg_en_r <= 1'b0;
			pin_oe_r <= 1'b0;
			pin_o_r  <= 1'b0;
		end else begin
			prg_en_r <= (state_nxt != S_OFF) && (state_nxt != S_EXIT);
			pin_oe_r <= (state_nxt == S_ENTER) || (state_nxt == S_HELD) || (state_nxt == S_LOW)
				|| (state_nxt == S_SEND) || (state_nxt == S_PUSH && kind_r != mpl_pkg::MPL_READ
				&& kind_r != mpl_pkg::MPL_WRITE_NVM);
			pin_o_r  <= (state_r == S_SEND) ? tx_line : 1'b0;
		end
	end
endmodule

// *** rtl/mpl_pkg.sv ***
// constants, types and the frame check for the manchester programming link controller
// assumes a 100 MHz controller clock and a sensor that answers on its single output pin
package mpl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// timing, all derived from the controller clock period
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned BIT_TIME_NS      = 39000;      // one bit, 39 us
	localparam logic [11:0] HALF_BIT_CYC     = 12'(BIT_TIME_NS / (2 * CLK_PERIOD_NS));
	localparam int unsigned LOW_HOLD_NS      = 1000;       // pin low before first edge
	localparam int unsigned LOW_HOLD_CYC     = (LOW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CMD_FIRST_NS     = 144000;     // first command after enable
	localparam int unsigned CMD_FIRST_CYC    = (CMD_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned NVM_WRITE_MAX_NS = 25000000;   // nonvolatile write delay, longest
	localparam int unsigned NVM_WAIT_CYC     = NVM_WRITE_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned RSP_WAIT_NS      = 8 * BIT_TIME_NS;
	localparam int unsigned RSP_WAIT_CYC     = RSP_WAIT_NS / CLK_PERIOD_NS;
	localparam int unsigned EXIT_GAP_NS      = BIT_TIME_NS;
	localparam int unsigned EXIT_GAP_CYC     = EXIT_GAP_NS / CLK_PERIOD_NS;
	localparam int unsigned RX_MASK_CYC      = (3 * HALF_BIT_CYC) / 2;   // ignore bit-boundary edges
	localparam int unsigned RX_LOST_CYC      = 3 * HALF_BIT_CYC;         // no mid-bit edge: lost

	////////////////////////////////////////////////////////////////////////////////
	// frame layout
	localparam int unsigned ADDR_W      = 6;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned PAYLOAD_W   = 26;
	localparam int unsigned ECC_W       = 2;
	localparam int unsigned ECC_LSB     = 26;
	localparam int unsigned CRC_W       = 3;
	localparam int unsigned CMD_FRAME_W = 44;   // sync, rw, address, data, crc
	localparam int unsigned ACK_FRAME_W = 37;   // sync, data, crc
	localparam int unsigned CRC_SPAN_W  = 39;   // rw, address, data
	localparam logic [1:0]  SYNC_VAL    = 2'h0;
	localparam logic        RW_WRITE    = 1'h0;
	localparam logic        RW_READ     = 1'h1;
	localparam logic [5:0]  UNLOCK_ADDR = 6'h36;
	localparam logic [2:0]  CRC_POLY    = 3'h3;
	localparam logic [2:0]  CRC_SEED    = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		MPL_UNLOCK,
		MPL_WRITE_VOL,
		MPL_WRITE_NVM,
		MPL_READ
	} mpl_kind_type;

	typedef enum logic [1:0] {
		MPL_OK,
		MPL_CRC_BAD,
		MPL_NO_REPLY
	} mpl_stat_type;

	typedef struct packed {
		mpl_kind_type          kind;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     data;
	} mpl_cmd_type;

	typedef struct packed {
		mpl_stat_type          status;
		logic [ECC_W-1:0]      ecc;
		logic [PAYLOAD_W-1:0]  data;
	} mpl_rsp_type;

	////////////////////////////////////////////////////////////////////////////////
	// three-bit frame check over the first n bits of a left-aligned field
	function automatic logic [2:0] mpl_crc3(input logic [CRC_SPAN_W-1:0] bits, input int n);
		logic [2:0] c;
		logic       fb;
		c = CRC_SEED;
		for (int i = 0; i < CRC_SPAN_W; i++) begin
			if (i < n) begin
				fb = c[2] ^ bits[CRC_SPAN_W-1-i];
				c  = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
			end
		end
		return c;
	endfunction

endpackage

// *** rtl/mpl_tx_bit.sv ***
// manchester encoder for one bit: low-high for zero, high-low for one
// assumes start is pulsed only while idle or in the cycle that done is high
`timescale 1ns/10ps
module mpl_tx_bit #(
	parameter logic [11:0] HALF_CYC = mpl_pkg::HALF_BIT_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	input  wire logic bit_val,
	output logic      line,
	output logic      done
);
	logic        busy_r;
	logic        half_r;
	logic        bit_r;
	logic [11:0] cnt_r;
	logic        last;

	assign last = (cnt_r == HALF_CYC - 12'h001);
	assign done = busy_r & half_r & last;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			half_r <= 1'b0;
			cnt_r  <= 12'h000;
			bit_r  <= 1'b0;
		end else if (start) begin
			busy_r <= 1'b1;
			half_r <= 1'b0;
			cnt_r  <= 12'h000;
			bit_r  <= bit_val;
		end else if (busy_r) begin
			cnt_r <= last ? 12'h000 : cnt_r + 12'h001;
			if (last) begin
				half_r <= ~half_r;
				busy_r <= ~half_r;
			end
		end
	end

	// mid-bit edge sense
	// first half carries the bit, second its inverse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line <= 1'b0;
		end else if (start) begin
			line <= bit_val;
		end else if (busy_r && last && !half_r) begin
			line <= ~bit_r;
		end
	end
endmodule

// *** rtl/mpl_fifo.sv ***
// small first-in first-out buffer held in flip-flops
// assumes the reader may stall; in_ready falls when every entry is used
`timescale 1ns/10ps
module mpl_fifo #(
	parameter int unsigned W     = 30,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_r [DEPTH];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] rd_r;
	logic [PW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + PW'(1);
			end
			if (pop) begin
				rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + PW'(1);
			end
			cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// *** test/mpl_checker.sv ***
// port checks on the programming link controller
// assumes a bind to mpl_top with every port connected by name
`timescale 1ns/10ps
module mpl_checker #(
	parameter logic [11:0] HALF_CYC = mpl_pkg::HALF_BIT_CYC
) (
	input wire logic                 MCLK,
	input wire logic                 RST_N,
	input wire logic                 CMD_VALID,
	input wire logic                 CMD_READY,
	input wire logic                 PRG_HOLD,
	input wire logic                 RSP_VALID,
	input wire logic                 RSP_READY,
	input wire mpl_pkg::mpl_rsp_type RSP,
	input wire logic                 BUSY,
	input wire logic                 PRG_EN_OUT,
	input wire logic                 SOUT_O,
	input wire logic                 SOUT_OE
);
	logic [15:0] gap_r;  // cycles since pin drive changed
	logic        last_r;

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////
	// spacing counter between pin edges
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			gap_r  <= 16'h0;
			last_r <= 1'b0;
		end else begin
			last_r <= SOUT_O;
			if (SOUT_O != last_r) begin
				gap_r <= 16'h0;
			end else if (gap_r != 16'hFFFF) begin
				gap_r <= gap_r + 16'h1;
			end
		end
	end

	////////////////////////////////////////
	// handshake, program level and pin timing
	a_take_busy: assert property (
		CMD_VALID && CMD_READY |=> BUSY && !CMD_READY) else $error("ready after take");
	a_enter_low: assert property (
		CMD_VALID && CMD_READY && !PRG_EN_OUT |-> ##[1:3] (PRG_EN_OUT && SOUT_OE && !SOUT_O))
		else $error("no program entry");
	a_lead_low: assert property (
		$rose(SOUT_OE) |-> !SOUT_O [*8]) else $error("pin not low first");
	a_half_bit: assert property (
		SOUT_OE && $past(SOUT_OE) && SOUT_O != last_r |-> gap_r >= {4'h0, HALF_CYC} - 16'h0001)
		else $error("pin edge too early");
	a_drive_prog: assert property (
		SOUT_OE |-> PRG_EN_OUT) else $error("pin driven outside program");
	a_exit_gap: assert property (
		$fell(PRG_EN_OUT) |-> !CMD_READY [*8]) else $error("no exit gap");
	a_hold_level: assert property (
		PRG_EN_OUT && PRG_HOLD && CMD_READY |=> PRG_EN_OUT) else $error("held level dropped");
	a_rsp_hold: assert property (
		RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP)) else $error("answer changed");
endmodule

// *** test/mpl_sensor_model.sv ***
// sensor side of the link: frame decoder, register store and replies
// assumes pin is the resolved wire, pulled low when nobody drives it
`timescale 1ns/10ps
module mpl_sensor_model #(
	parameter logic [31:0] UNLOCK_CODE = 32'h5A5A1234,  // arbitrary access code
	parameter logic [5:0]  NVM_FIRST   = 6'h20,         // first nonvolatile address
	parameter int unsigned NVM_DLY     = 2000,          // shortened write delay
	parameter logic [11:0] HALF_CYC    = 12'h79E,       // half bit in clock cycles
	parameter logic [5:0]  LOCK_ADDR   = 6'h3F,         // permanent lock register, arbitrary
	parameter int unsigned LOCK_BIT    = 25,            // permanent lock bit, arbitrary
	parameter logic [1:0]  ECC_FLAG    = 2'h1           // ecc status sent on reads, arbitrary
) (
	input  wire logic clk,
	input  wire logic prg_en,
	input  wire logic pin,
	input  wire logic power_cycle,
	input  wire logic bad_crc,
	output logic      s_o,
	output logic      s_oe
);
	logic [25:0] mem [64];
	logic [43:0] f;
	logic [31:0] d;
	logic [36:0] r;
	logic        unlocked;
	logic        perm;

	////////////////////////////////////////
	// msb-first three-bit check
	function automatic logic [2:0] chk3(input logic [38:0] v, input int n);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < n; i++) begin
			c = {c[1:0], 1'b0} ^ ((c[2] ^ v[38-i]) ? 3'h3 : 3'h0);
		end
		return c;
	endfunction

	task automatic send_bit(input logic b);
		s_o = b;
		repeat (HALF_CYC) @(negedge clk);
		s_o = !b;
		repeat (HALF_CYC) @(negedge clk);
	endtask

	// power cycle relocks, a set lock bit locks for good
	always @(posedge power_cycle) begin
		unlocked = 1'b0;
		perm = perm | mem[LOCK_ADDR][LOCK_BIT];
	end

	initial begin
		s_o = 1'b0;
		s_oe = 1'b0;
		unlocked = 1'b0;
		perm = 1'b0;
		foreach (mem[i]) mem[i] = 26'h0;
		forever begin
			@(posedge pin iff prg_en);
			f[43] = 1'b0;
			repeat ((3 * HALF_CYC) / 2) @(negedge clk);
			for (int k = 42; k >= 0; k--) begin
				f[k] = pin;
				repeat (2 * HALF_CYC) @(negedge clk);
			end
			if (f[43:42] == 2'h0 && chk3(f[41:3], 39) == f[2:0]) begin
				if (!f[41] && f[40:35] == 6'h36) begin
					unlocked = (f[34:3] == UNLOCK_CODE && !perm) ? 1'b1 : unlocked;
				end else if (!f[41] && unlocked) begin
					mem[f[40:35]] = f[28:3];
					if (f[40:35] >= NVM_FIRST) begin
						repeat (NVM_DLY) @(negedge clk);
						s_oe = 1'b1;
						s_o = 1'b1;
						repeat (100) @(negedge clk);
						s_o = 1'b0;
						repeat (10) @(negedge clk);
						s_oe = 1'b0;
					end
				end else if (f[41] && unlocked) begin
					d = {4'h0, ECC_FLAG, mem[f[40:35]]};
					r = {2'h0, d, chk3({d, 7'h0}, 32) ^ {2'h0, bad_crc}};
					s_oe = 1'b1;
					repeat (300) @(negedge clk);
					for (int k = 36; k >= 0; k--) begin
						send_bit(r[k]);
					end
					s_o = 1'b0;
					repeat (10) @(negedge clk);
					s_oe = 1'b0;
				end
			end
		end
	end
endmodule

// *** test/mpl_top_tb.sv ***
// self-checking bench for the programming link controller
// assumes the sensor model on the pin and a pull-down on the wire
`timescale 1ns/10ps
module mpl_top_tb;
	localparam logic [31:0] CODE = 32'h5A5A1234;  // arbitrary access code
	localparam logic [11:0] HALF = 12'h014;       // shortened half bit
	localparam logic [1:0]  ECC  = 2'h1;          // arbitrary ecc status
	logic                 mclk, rst_n, cmd_valid, cmd_ready, prg_hold, rsp_valid, rsp_ready;
	logic                 busy, prg_en, sout_o, sout_oe, pin, s_o, s_oe, pwr, bad;
	mpl_pkg::mpl_cmd_type cmd;
	mpl_pkg::mpl_rsp_type rsp, got;
	int                   err_count, checks;

	always #5 mclk = !mclk;
	assign pin = sout_oe ? sout_o : (s_oe ? s_o : 1'b0);

	mpl_top #(.CMD_FIRST_CYC(20), .NVM_WAIT_CYC(5000), .RSP_WAIT_CYC(1000),
		.HALF_CYC(HALF)) DUT (
		.MCLK(mclk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD(cmd),
		.PRG_HOLD(prg_hold), .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .RSP(rsp),
		.BUSY(busy), .PRG_EN_OUT(prg_en), .SOUT_I(pin), .SOUT_O(sout_o), .SOUT_OE(sout_oe));
	mpl_sensor_model #(.UNLOCK_CODE(CODE), .HALF_CYC(HALF), .ECC_FLAG(ECC)) u_sensor (
		.clk(mclk), .prg_en(prg_en), .pin(pin),
		.power_cycle(pwr), .bad_crc(bad), .s_o(s_o), .s_oe(s_oe));

	////////////////////////////////////////
	// compares and verdict
	task automatic cmp_bit(input string what, input logic exp, input logic seen);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmp_st(input string what, input mpl_pkg::mpl_stat_type exp,
		input mpl_pkg::mpl_stat_type seen);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmp_rsp(input string what, input mpl_pkg::mpl_rsp_type exp,
		input mpl_pkg::mpl_rsp_type seen);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////
	// command and answer handshakes
	task automatic send(input mpl_pkg::mpl_kind_type k, input logic [5:0] a,
		input logic [31:0] dv, input logic hold);
		int n;
		n = 0;
		@(negedge mclk);
		cmd = {k, a, dv};
		prg_hold = hold;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 600000) begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		cmd_valid = 1'b0;
		err_count += (n >= 600000) ? 1 : 0;
	endtask
	task automatic get(output mpl_pkg::mpl_rsp_type rv);
		int n;
		n = 0;
		@(negedge mclk);
		rsp_ready = 1'b1;
		while (rsp_valid !== 1'b1 && n < 600000) begin
			@(negedge mclk);
			n++;
		end
		rv = rsp;
		@(negedge mclk);
		rsp_ready = 1'b0;
		err_count += (n >= 600000) ? 1 : 0;
	endtask
	function automatic mpl_pkg::mpl_rsp_type ok(input logic [25:0] dv);
		return {mpl_pkg::MPL_OK, 2'h0, dv};
	endfunction

	////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		cmp_bit("ready", 1'b1, cmd_ready);
		cmp_bit("rsp_valid", 1'b0, rsp_valid);
		cmp_bit("prg_en", 1'b0, prg_en);
		cmp_bit("sout_oe", 1'b0, sout_oe);
		$display("test reset done");
	endtask
	task automatic t_locked;
		send(mpl_pkg::MPL_WRITE_NVM, 6'h21, 32'h0000_1111, 1'b1);
		send(mpl_pkg::MPL_READ, 6'h05, 32'h0, 1'b1);
		cmp_bit("stalled valid", 1'b1, rsp_valid);
		get(got);
		cmp_st("locked nvm", mpl_pkg::MPL_NO_REPLY, got.status);
		get(got);
		cmp_st("locked read", mpl_pkg::MPL_NO_REPLY, got.status);
		$display("test locked done");
	endtask
	task automatic t_unlock_rw;
		send(mpl_pkg::MPL_UNLOCK, 6'h00, CODE, 1'b1);
		get(got);
		cmp_rsp("unlock", ok(26'h0), got);
		send(mpl_pkg::MPL_WRITE_VOL, 6'h05, 32'hFD2BC0DE, 1'b1);
		get(got);
		cmp_rsp("write vol", ok(26'h0), got);
		cmp_bit("held prg_en", 1'b1, prg_en);
		send(mpl_pkg::MPL_WRITE_NVM, 6'h21, 32'h0000_2222, 1'b1);
		get(got);
		cmp_rsp("write nvm", ok(26'h0), got);
		send(mpl_pkg::MPL_READ, 6'h05, 32'h0, 1'b1);
		get(got);
		cmp_rsp("read", {mpl_pkg::MPL_OK, ECC, 26'h12BC0DE}, got);
		$display("test unlock done");
	endtask
	task automatic t_crc_bad;
		bad = 1'b1;
		send(mpl_pkg::MPL_READ, 6'h21, 32'h0, 1'b0);
		get(got);
		bad = 1'b0;
		cmp_st("bad check", mpl_pkg::MPL_CRC_BAD, got.status);
		repeat (5) @(negedge mclk);
		cmp_bit("exit prg_en", 1'b0, prg_en);
		$display("test check done");
	endtask
	task automatic t_power;
		send(mpl_pkg::MPL_WRITE_NVM, 6'h3F, 32'h0200_0000, 1'b0);
		get(got);
		cmp_rsp("lock bit", ok(26'h0), got);
		pwr = 1'b1;
		@(negedge mclk);
		pwr = 1'b0;
		send(mpl_pkg::MPL_READ, 6'h05, 32'h0, 1'b1);
		get(got);
		cmp_st("relocked", mpl_pkg::MPL_NO_REPLY, got.status);
		send(mpl_pkg::MPL_UNLOCK, 6'h00, CODE, 1'b1);
		get(got);
		cmp_rsp("late unlock", ok(26'h0), got);
		send(mpl_pkg::MPL_READ, 6'h05, 32'h0, 1'b0);
		get(got);
		cmp_st("locked for good", mpl_pkg::MPL_NO_REPLY, got.status);
		$display("test power done");
	endtask

	// main sequence
	initial begin
		{mclk, rst_n, cmd_valid, prg_hold, rsp_ready, pwr, bad} = 7'h00;
		cmd = '0;
		err_count = 0;
		checks = 0;
		repeat (10) @(negedge mclk);
		t_reset;
		rst_n = 1'b1;
		t_locked;
		t_unlock_rw;
		t_crc_bad;
		t_power;
		stop_test;
	end

	// watchdog against a hang
	initial begin
		repeat (80000) @(posedge mclk);
		err_count++;
		stop_test;
	end
endmodule

bind mpl_top mpl_checker #(.HALF_CYC(HALF_CYC)) u_chk (.MCLK(MCLK), .RST_N(RST_N),
	.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .PRG_HOLD(PRG_HOLD), .RSP_VALID(RSP_VALID),
	.RSP_READY(RSP_READY), .RSP(RSP), .BUSY(BUSY), .PRG_EN_OUT(PRG_EN_OUT), .SOUT_O(SOUT_O),
	.SOUT_OE(SOUT_OE));
